// ==== src/watchdog_consts.vh ====
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define AUX_CTRL_IDX 10'h08E
`define SERVICE_PORT_IDX 10'h0A6
`define WD_STATUS_IDX 10'h0F0

// ----------------------------------------------------------------------
// auxiliary_control fields and reset value
// ----------------------------------------------------------------------
`define AUX_ALE_OFF_BIT 0
`define AUX_RESET_OUT_DISABLE_BIT 3
`define AUX_IDLE_COUNT_HOLD_BIT 4
`define AUX_RESET_VAL 8'h00
`define AUX_WRITE_MASK 8'h19

// ----------------------------------------------------------------------
// watchdog_status fields
// ----------------------------------------------------------------------
`define STAT_ENABLED_BIT 0
`define STAT_PULSE_BIT 1
`define STAT_WAKE_HOLD_BIT 2
`define STAT_ARMED_BIT 3

// ----------------------------------------------------------------------
// service sequence and counter
// ----------------------------------------------------------------------
`define SERVICE_FIRST 8'h1E
`define SERVICE_SECOND 8'hE1
`define WD_CNT_MAX 13'h1FFF
`define WD_CNT_ZERO 13'h0000

// ----------------------------------------------------------------------
// timing: oscillator period equals the aclk period
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS 10000
`define OSC_PERIOD_PS 10000
`define MACHINE_CYCLE_OSC 12
`define MACHINE_CYCLE_CLKS ((`MACHINE_CYCLE_OSC * `OSC_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_PULSE_OSC 98
`define RESET_PULSE_CLKS ((`RESET_PULSE_OSC * `OSC_PERIOD_PS) / `CLK_PERIOD_PS)
`define PIN_RESET_MCYCLES 2

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== src/machine_cycle_timer.v ====
// divider that marks the end of each machine cycle
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module machine_cycle_timer (
   input wire aclk,
   input wire aresetn,
   input wire run,
   input wire clear,
   output reg tick_ff
);

   reg [3:0] phase_ff;
   reg [3:0] nxt_phase;
   reg nxt_tick;
   // last phase of a machine cycle, cut to the counter width on purpose
   localparam [31:0] LAST_PHASE = `MACHINE_CYCLE_CLKS - 1;

   // -------------------------------------------------------------------
   // phase counter
   // -------------------------------------------------------------------
   // freezes while run is low, as a stopped oscillator would
   always @* begin
      nxt_phase = phase_ff;
      nxt_tick = 1'b0;
      if (clear) begin
         nxt_phase = 4'h0;
      end else if (run) begin
         if (phase_ff == LAST_PHASE[3:0]) begin
            nxt_phase = 4'h0;
            nxt_tick = 1'b1;
         end else begin
            nxt_phase = phase_ff + 4'h1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_ff <= 4'h0;
         tick_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         tick_ff <= nxt_tick;
      end
   end

endmodule
`default_nettype wire

// ==== src/reset_pulse_gen.v ====
// timed high pulse for the reset pin after a watchdog overflow
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module reset_pulse_gen (
   input wire aclk,
   input wire aresetn,
   input wire start,
   output reg pulse_ff
);

   reg [6:0] left_ff;
   reg [6:0] nxt_left;
   reg nxt_pulse;
   // countdown start value, cut to the counter width on purpose
   localparam [31:0] PULSE_LAST = `RESET_PULSE_CLKS - 1;

   // -------------------------------------------------------------------
   // countdown
   // -------------------------------------------------------------------
   // a new start while running restarts the full length
   always @* begin
      nxt_left = left_ff;
      nxt_pulse = pulse_ff;
      if (start) begin
         nxt_left = PULSE_LAST[6:0];
         nxt_pulse = 1'b1;
      end else if (pulse_ff) begin
         if (left_ff == 7'h00) begin
            nxt_pulse = 1'b0;
         end else begin
            nxt_left = left_ff - 7'h01;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         left_ff <= 7'h00;
         pulse_ff <= 1'b0;
      end else begin
         left_ff <= nxt_left;
         pulse_ff <= nxt_pulse;
      end
   end

endmodule
`default_nettype wire

// ==== src/watchdog_with_reset_out.v ====
// one-time-enabled watchdog with reset-out pulse and AXI4-Lite registers
// Contract
// [R1] watchdog idle after reset until enabled
// [R2] 1E then E1 to service port enables
// [R3] enabled 13-bit counter advances each machine cycle
// [R4] only a device reset disables it
// [R5] count reaching 1FFF resets the device
// [R6] 1E then E1 while enabled clears counter
// [R7] software services within 8191 machine cycles
// [R8] service port write-only, counter not accessible
// [R9] overflow drives reset pin high 98 periods
// [R10] reset_out_disable bit suppresses the pin pulse
// [R11] reset pin high two machine cycles resets
// [R12] power-down stops counting, no service needed
// [R13] after interrupt wake, hold until pin high
// [R14] idle_count_hold clear: count during idle
// [R15] idle_count_hold set: pause during idle
// [R16] software services right before power-down
// [R17] machine cycle spans twelve oscillator periods
// [R18] other value between bytes abandons sequence
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"

module watchdog_with_reset_out (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire reset_pin_in,
   output wire reset_pin_out,
   output wire reset_pin_oe,
   input wire idle_mode,
   input wire power_down,
   input wire wake_int_n,
   output reg device_reset_ff
);

   // -------------------------------------------------------------------
   // address decode helper
   // -------------------------------------------------------------------
   function is_reg;
      input [11:0] addr;
      input [9:0] idx;
      begin
         is_reg = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   reg [11:0] aw_addr_ff;
   reg aw_held_ff;
   reg [7:0] w_byte_ff;
   reg w_lane_ff;
   reg w_held_ff;
   reg [7:0] aux_ctrl_ff;
   reg enabled_ff;
   reg armed_ff;
   reg [12:0] wd_cnt_ff;
   reg wake_hold_ff;
   reg power_down_d_ff;
   reg [1:0] pin_mcyc_ff;
   reg pin_meta_ff;
   reg pin_sync_ff;
   reg wake_meta_ff;
   reg wake_sync_ff;
   reg [7:0] nxt_aux;
   reg nxt_enabled;
   reg nxt_armed;
   reg [12:0] nxt_cnt;
   reg [1:0] nxt_pin_mcyc;
   reg nxt_wake_hold;
   reg [31:0] nxt_rdata;
   reg [1:0] nxt_rresp;
   wire mc_tick;
   wire pulse_active;
   wire do_write;
   wire svc_write;
   wire svc_done;
   wire overflow;
   wire pin_reset;
   wire count_run;
   wire soft_reset;

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   // reset pin and wake interrupt come from outside the clock domain
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
         wake_meta_ff <= 1'b1;
         wake_sync_ff <= 1'b1;
         power_down_d_ff <= 1'b0;
      end else begin
         pin_meta_ff <= reset_pin_in;
         pin_sync_ff <= pin_meta_ff;
         wake_meta_ff <= wake_int_n;
         wake_sync_ff <= wake_meta_ff;
         power_down_d_ff <= power_down;
      end
   end

   // -------------------------------------------------------------------
   // write channel capture
   // -------------------------------------------------------------------
   // address and data are taken in either order, then applied together
   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;
   assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_ff <= 12'h000;
         aw_held_ff <= 1'b0;
         w_byte_ff <= 8'h00;
         w_lane_ff <= 1'b0;
         w_held_ff <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_ff) begin
            aw_addr_ff <= s_axi_awaddr;
            aw_held_ff <= 1'b1;
         end
         if (s_axi_wvalid && !w_held_ff) begin
            w_byte_ff <= s_axi_wdata[7:0];
            w_lane_ff <= s_axi_wstrb[0];
            w_held_ff <= 1'b1;
         end
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (is_reg(aw_addr_ff, `AUX_CTRL_IDX) ||
                is_reg(aw_addr_ff, `SERVICE_PORT_IDX) ||
                is_reg(aw_addr_ff, `WD_STATUS_IDX)) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // service sequence decode
   // -------------------------------------------------------------------
   // only the low byte lane carries the 8-bit register
   assign svc_write = do_write && w_lane_ff &&
                      is_reg(aw_addr_ff, `SERVICE_PORT_IDX);
   assign svc_done = svc_write && armed_ff &&
                     (w_byte_ff == `SERVICE_SECOND);

   // -------------------------------------------------------------------
   // counting conditions
   // -------------------------------------------------------------------
   // [R12] stop in power-down
   // [R14] idle counts by default
   // [R15] idle pauses when held
   assign count_run = enabled_ff && !power_down && !wake_hold_ff &&
      !(idle_mode && aux_ctrl_ff[`AUX_IDLE_COUNT_HOLD_BIT]);
   // [R5] overflow at full count
   assign overflow = enabled_ff && (wd_cnt_ff == `WD_CNT_MAX);
   // [R11] pin held two cycles
   // the first tick closes a partial cycle, so one extra tick is counted
   localparam [31:0] PIN_MCYC_LAST = `PIN_RESET_MCYCLES + 1;
   assign pin_reset = (pin_mcyc_ff == PIN_MCYC_LAST[1:0]);
   assign soft_reset = overflow || pin_reset;

   // [R17] twelve-period machine cycle
   machine_cycle_timer u_mc_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(!power_down),
      .clear(soft_reset),
      .tick_ff(mc_tick)
   );

   // [R9] pulse on overflow
   // [R10] suppressed by disable bit
   reset_pulse_gen u_pulse (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(overflow && !aux_ctrl_ff[`AUX_RESET_OUT_DISABLE_BIT]),
      .pulse_ff(pulse_active)
   );

   // the pin is only ever driven high, otherwise left to the outside
   assign reset_pin_out = pulse_active;
   assign reset_pin_oe = pulse_active;

   // -------------------------------------------------------------------
   // watchdog next state
   // -------------------------------------------------------------------
   always @* begin
      nxt_aux = aux_ctrl_ff;
      nxt_enabled = enabled_ff;
      nxt_armed = armed_ff;
      nxt_cnt = wd_cnt_ff;
      nxt_wake_hold = wake_hold_ff;
      nxt_pin_mcyc = pin_mcyc_ff;
      if (do_write && w_lane_ff && is_reg(aw_addr_ff, `AUX_CTRL_IDX)) begin
         nxt_aux = w_byte_ff & `AUX_WRITE_MASK;
      end
      if (svc_write) begin
         // [R18] stray byte abandons
         nxt_armed = (w_byte_ff == `SERVICE_FIRST);
      end
      // [R3] advance each machine cycle
      if (count_run && mc_tick) begin
         nxt_cnt = wd_cnt_ff + 13'h0001;
      end
      if (svc_done) begin
         // [R2] ordered pair enables
         nxt_enabled = 1'b1;
         // [R6] service clears count
         nxt_cnt = `WD_CNT_ZERO;
      end
      // [R13] hold after interrupt wake
      if (power_down_d_ff && !power_down && !wake_sync_ff) begin
         nxt_wake_hold = 1'b1;
      end else if (wake_sync_ff) begin
         nxt_wake_hold = 1'b0;
      end
      // own drive of the pin must not count as an external reset
      if (!pin_sync_ff || pulse_active || power_down) begin
         nxt_pin_mcyc = 2'h0;
      end else if (mc_tick && !pin_reset) begin
         nxt_pin_mcyc = pin_mcyc_ff + 2'h1;
      end
      // [R4] only device reset disables
      if (soft_reset) begin
         nxt_aux = `AUX_RESET_VAL;
         nxt_enabled = 1'b0;
         nxt_armed = 1'b0;
         nxt_cnt = `WD_CNT_ZERO;
         nxt_wake_hold = 1'b0;
         nxt_pin_mcyc = 2'h0;
      end
   end

   // [R1] inactive out of reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         aux_ctrl_ff <= `AUX_RESET_VAL;
         enabled_ff <= 1'b0;
         armed_ff <= 1'b0;
         wd_cnt_ff <= `WD_CNT_ZERO;
         wake_hold_ff <= 1'b0;
         pin_mcyc_ff <= 2'h0;
         device_reset_ff <= 1'b0;
      end else begin
         aux_ctrl_ff <= nxt_aux;
         enabled_ff <= nxt_enabled;
         armed_ff <= nxt_armed;
         wd_cnt_ff <= nxt_cnt;
         wake_hold_ff <= nxt_wake_hold;
         pin_mcyc_ff <= nxt_pin_mcyc;
         device_reset_ff <= soft_reset;
      end
   end

   // -------------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------------
   // one read at a time; new address taken only once the answer is gone
   assign s_axi_arready = !s_axi_rvalid;

   // [R8] counter never readable
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_rresp = `RESP_OKAY;
      if (is_reg(s_axi_araddr, `AUX_CTRL_IDX)) begin
         nxt_rdata[7:0] = aux_ctrl_ff;
      end else if (is_reg(s_axi_araddr, `WD_STATUS_IDX)) begin
         nxt_rdata[`STAT_ENABLED_BIT] = enabled_ff;
         nxt_rdata[`STAT_PULSE_BIT] = pulse_active;
         nxt_rdata[`STAT_WAKE_HOLD_BIT] = wake_hold_ff;
         nxt_rdata[`STAT_ARMED_BIT] = armed_ff;
      end else if (!is_reg(s_axi_araddr, `SERVICE_PORT_IDX)) begin
         nxt_rresp = `RESP_SLVERR;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= nxt_rdata;
         s_axi_rresp <= nxt_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== test/watchdog_properties.sv ====
// port-level assertions for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module watchdog_properties (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire reset_pin_in,
   input wire reset_pin_out,
   input wire reset_pin_oe,
   input wire device_reset_ff
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] hi_ff;
   // run length of the pin pulse, cleared once the pin drops
   always_ff @(posedge aclk) begin
      if (!aresetn) hi_ff <= 8'h00;
      else if (reset_pin_out) hi_ff <= hi_ff + 8'h01;
      else hi_ff <= 8'h00;
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && !s_axi_bvalid;
   endsequence
   sequence s_wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_pulse_len;
      $fell(reset_pin_out) |-> hi_ff == 8'h62;
   endproperty
   property p_pulse_cause;
      $rose(reset_pin_out) |-> device_reset_ff;
   endproperty
   property p_oe_follows;
      reset_pin_oe == reset_pin_out;
   endproperty
   property p_reset_one;
      device_reset_ff |=> !device_reset_ff;
   endproperty
   property p_pin_qualify;
      $rose(reset_pin_in) |=> !device_reset_ff [*8];
   endproperty
   property p_write_lat;
      s_wr_taken |=> s_wr_answer;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_read_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pin pulse length wrong");
   a_pulse_cause: assert property (p_pulse_cause)
      else $error("reset pin pulse without overflow");
   a_oe_follows: assert property (p_oe_follows)
      else $error("pin enable differs from pin level");
   a_reset_one: assert property (p_reset_one)
      else $error("device reset longer than one cycle");
   a_pin_qualify: assert property (p_pin_qualify)
      else $error("pin reset taken too early");
   a_write_lat: assert property (p_write_lat)
      else $error("write answer late");
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
   a_read_lat: assert property (p_read_lat)
      else $error("read answer late");
endmodule
bind watchdog_with_reset_out watchdog_properties watchdog_properties_i (.*);
`default_nettype wire

// ==== test/watchdog_with_reset_out_tb.sv ====
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.vh"
module watchdog_with_reset_out_tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [11:0] AUX = {`AUX_CTRL_IDX, 2'b00};
   localparam logic [11:0] SVC = {`SERVICE_PORT_IDX, 2'b00};
   localparam logic [11:0] STA = {`WD_STATUS_IDX, 2'b00};
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_in;
   logic reset_pin_out, reset_pin_oe, idle_mode, power_down, wake_int_n;
   logic device_reset_ff;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares, checked, cyc, hi_n, n, t_s;
   watchdog_with_reset_out watchdog_with_reset_out_i (.*);
   // free-running clock plus cycle and pulse counters
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (reset_pin_out === 1'b1) hi_n <= hi_n + 1;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic summarize;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tmo(input int lim);
      if (n >= lim) begin
         miscompares++;
         summarize();
      end
   endtask
   // write one byte; ready is sampled mid-cycle, acted on at the edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 50 && !b; n++) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      tmo(50);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic r, ar;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 1'b0;
      for (n = 0; n < 50 && !r; n++) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      tmo(50);
      chk("rdata", s_axi_rdata, ed);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // wait for a device reset request, bounded
   task automatic wait_rst(input int lim);
      for (n = 0; n < lim && device_reset_ff !== 1'b1; n++) @(negedge aclk);
      tmo(lim);
      @(posedge aclk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, reset_pin_in, idle_mode} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {s_axi_awprot, s_axi_arprot, power_down} = 7'h00;
      {miscompares, checked, cyc, hi_n} = 128'h0;
      wake_int_n = 1'b1;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(STA, 32'h0, `RESP_OKAY);
      rd(AUX, 32'h0, `RESP_OKAY);
      rd(SVC, 32'h0, `RESP_OKAY);
      rd(12'h004, 32'h0, `RESP_SLVERR);
      wr(12'h004, `SERVICE_FIRST, `RESP_SLVERR);
      wr(AUX, 8'hFF, `RESP_OKAY);
      rd(AUX, 32'h19, `RESP_OKAY);
      wr(SVC, `SERVICE_FIRST, `RESP_OKAY);
      rd(STA, 32'h08, `RESP_OKAY);
      wr(SVC, 8'h55, `RESP_OKAY);
      wr(SVC, `SERVICE_SECOND, `RESP_OKAY);
      rd(STA, 32'h0, `RESP_OKAY);
      // pin held high: two machine cycles plus sync, soft reset clears aux
      reset_pin_in <= 1'b1;
      wait_rst(60);
      chk("pin_delay", {31'h0, n >= 24 && n <= 45}, 32'h1);
      reset_pin_in <= 1'b0;
      rd(AUX, 32'h0, `RESP_OKAY);
      wr(SVC, `SERVICE_FIRST, `RESP_OKAY);
      wr(SVC, `SERVICE_SECOND, `RESP_OKAY);
      rd(STA, 32'h01, `RESP_OKAY);
      wr(SVC, 8'h00, `RESP_OKAY);
      wr(AUX, 8'h00, `RESP_OKAY);
      wr(SVC, `SERVICE_FIRST, `RESP_OKAY);
      wr(SVC, 8'h33, `RESP_OKAY);
      rd(STA, 32'h01, `RESP_OKAY);
      // service right before power-down; wake low keeps counting held
      wr(SVC, `SERVICE_FIRST, `RESP_OKAY);
      wr(SVC, `SERVICE_SECOND, `RESP_OKAY);
      t_s = cyc;
      power_down <= 1'b1;
      wake_int_n <= 1'b0;
      repeat (300) @(posedge aclk);
      power_down <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(STA, 32'h05, `RESP_OKAY);
      repeat (287) @(posedge aclk);
      wake_int_n <= 1'b1;
      // idle without hold still counts; with hold it pauses
      idle_mode <= 1'b1;
      repeat (300) @(posedge aclk);
      wr(AUX, 8'h10, `RESP_OKAY);
      repeat (300) @(posedge aclk);
      idle_mode <= 1'b0;
      wait_rst(100000);
      n = cyc - t_s - 900 - 98292;
      chk("overflow_time", {31'h0, n >= -30 && n <= 30}, 32'h1);
      rd(STA, 32'h02, `RESP_OKAY);
      for (n = 0; n < 120 && reset_pin_out !== 1'b0; n++) @(negedge aclk);
      tmo(120);
      chk("pulse_len", hi_n, 32'd98);
      summarize();
   end
endmodule
`default_nettype wire
